// File: rtl/gca_conv_seq.sv
// conversion sequencer: single, chopped and continuous conversions
// assumes the core answers a held sample_req with a one-cycle sample_valid
`timescale 1ns/1ps
module gca_conv_seq import gca_pkg::*; #(
    parameter int RES_W = 16,
    parameter int GW = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic chop,
    input wire logic sign,
    input wire logic cont,
    input wire logic [GW-1:0] gap,
    input wire logic sample_valid,
    input wire logic [RES_W-1:0] sample_data,
    output logic sample_req_ff,
    output logic sample_sign_ff,
    output logic res_valid_ff,
    output logic [RES_W-1:0] res_ff,
    output logic fin_ff
);
    gca_seq_t st_ff;
    logic second_ff;
    logic [RES_W-1:0] first_ff;
    logic [GW-1:0] gap_ff;
    logic last;
    logic [RES_W:0] nxt_sum;

    // chopped conversions end after the second sample only
    assign last = sample_valid && (!chop || second_ff);
    assign nxt_sum = {1'b0, first_ff} + {1'b0, sample_data};

    // ****************************************
    // sequence control
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= S_IDLE;
            sample_req_ff <= 1'b0;
            sample_sign_ff <= 1'b0;
            second_ff <= 1'b0;
            gap_ff <= '0;
            fin_ff <= 1'b0;
        end else begin
            fin_ff <= 1'b0;
            unique case (st_ff)
                S_IDLE: begin
                    if (go) begin
                        st_ff <= S_BUSY;
                        sample_req_ff <= 1'b1;
                        sample_sign_ff <= sign;
                        second_ff <= 1'b0;
                    end
                end
                S_BUSY: begin
                    if (sample_valid && chop && !second_ff) begin
                        second_ff <= 1'b1;
                        sample_sign_ff <= ~sample_sign_ff; // R3
                    end else if (last && cont && gap == '0) begin
                        second_ff <= 1'b0; // R14
                        sample_sign_ff <= sign;
                    end else if (last && cont) begin
                        st_ff <= S_GAP; // R14
                        sample_req_ff <= 1'b0;
                        gap_ff <= gap;
                    end else if (last) begin
                        st_ff <= S_IDLE; // R11
                        sample_req_ff <= 1'b0;
                        fin_ff <= 1'b1;
                    end
                end
                S_GAP: begin
                    if (!cont) begin
                        st_ff <= S_IDLE;
                        fin_ff <= 1'b1;
                    end else if (gap_ff == GW'(1)) begin
                        st_ff <= S_BUSY;
                        sample_req_ff <= 1'b1;
                        sample_sign_ff <= sign;
                        second_ff <= 1'b0;
                    end else begin
                        gap_ff <= gap_ff - GW'(1);
                    end
                end
            endcase
        end
    end

    // ****************************************
    // result capture, chopped pair averaged
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_ff <= '0;
            res_ff <= '0;
            res_valid_ff <= 1'b0;
        end else begin
            res_valid_ff <= st_ff == S_BUSY && last;
            if (st_ff == S_BUSY && sample_valid && chop && !second_ff) begin
                first_ff <= sample_data;
            end
            if (st_ff == S_BUSY && last) begin
                res_ff <= chop ? nxt_sum[RES_W:1] : sample_data; // R3
            end
        end
    end
endmodule

// File: rtl/gca_evt_irq.sv
// sticky event status with read-clear, mask and one level interrupt
// assumes events are one-cycle pulses in the clk domain
`timescale 1ns/1ps
module gca_evt_irq #(
    parameter int N = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [N-1:0] ev,
    input wire logic rd_clr,
    input wire logic [N-1:0] mask,
    output logic [N-1:0] stat_ff,
    output logic irq_ff
);
    logic [N-1:0] nxt_stat;

    // an event in the clearing read's cycle survives the clear
    always_comb begin
        nxt_stat = (rd_clr ? '0 : stat_ff) | ev;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            stat_ff <= nxt_stat;
            irq_ff <= |(nxt_stat & mask);
        end
    end
endmodule

// File: rtl/gca_pkg.sv
// shared constants and types of the converter register bank
// assumes a 16-bit register port and an external analog converter core
package gca_pkg;

    // ****************************************
    // register addresses
    // ****************************************
    localparam int AW = 32;
    localparam int DW = 16;
    localparam logic [AW-1:0] OFS_CTRL = 32'h5000_1500;
    localparam logic [AW-1:0] OFS_CTRL2 = 32'h5000_1502;
    localparam logic [AW-1:0] OFS_CTRL3 = 32'h5000_1504;
    localparam logic [AW-1:0] OFS_SEL = 32'h5000_1506;
    localparam logic [AW-1:0] OFS_OFFP = 32'h5000_1508;
    localparam logic [AW-1:0] OFS_OFFN = 32'h5000_150A;
    localparam logic [AW-1:0] OFS_TRIM = 32'h5000_150C;
    localparam logic [AW-1:0] OFS_CLEAR = 32'h5000_150E;
    localparam logic [AW-1:0] OFS_RESULT = 32'h5000_1510;
    localparam logic [AW-1:0] OFS_EVT_STAT = 32'h5000_1512;
    localparam logic [AW-1:0] OFS_EVT_MASK = 32'h5000_1514;

    // ****************************************
    // main control fields
    // ****************************************
    localparam int B_TEMP = 12;
    localparam int B_HOLD = 10;
    localparam int B_CHOP = 9;
    localparam int B_SIGN = 8;
    localparam int B_MUTE = 7;
    localparam int B_SE = 6;
    localparam int B_MINT = 5;
    localparam int B_INT = 4;
    localparam int B_DMA = 3;
    localparam int B_CONT = 2;
    localparam int B_START = 1;
    localparam int B_EN = 0;
    localparam logic [DW-1:0] CTRL_RW_MASK = 16'h17ED;
    localparam int GAP_LSB = 8;
    localparam int GAP_W = 8;
    localparam int TEMP_CHANNEL = 4;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [DW-1:0] RST_CTRL = 16'h0000;
    localparam logic [DW-1:0] RST_CTRL2 = 16'h0210;
    localparam logic [DW-1:0] RST_CTRL3 = 16'h0000;
    localparam logic [DW-1:0] RST_SEL = 16'h0000;
    localparam logic [DW-1:0] RST_OFFP = 16'h0000;
    localparam logic [DW-1:0] RST_OFFN = 16'h0000;
    localparam logic [DW-1:0] RST_TRIM = 16'h0000;

    // ****************************************
    // event status bits
    // ****************************************
    localparam int EV_DONE = 0;
    localparam int EV_REFUSED = 1;
    localparam int EV_OVERRUN = 2;
    localparam int EV_N = 3;

    typedef enum logic [3:0] {
        RI_CTRL, RI_CTRL2, RI_CTRL3, RI_SEL, RI_OFFP, RI_OFFN, RI_TRIM,
        RI_CLEAR, RI_RESULT, RI_STAT, RI_MASK, RI_NONE
    } gca_reg_t;

    typedef enum logic [1:0] {S_IDLE, S_BUSY, S_GAP} gca_seq_t;

    typedef struct packed {
        logic temp_on_ch4;
        logic ref_hold;
        logic mute;
        logic single_ended;
        logic conv_en;
        logic dma_en;
    } gca_ana_t;

    typedef struct packed {
        logic [DW-1:0] ctrl2;
        logic [DW-1:0] ctrl3;
        logic [DW-1:0] sel;
        logic [DW-1:0] offp;
        logic [DW-1:0] offn;
        logic [DW-1:0] trim;
    } gca_cfg_t;

endpackage

// File: rtl/gca_regbank.sv
// register bank and control of the general converter
// assumes one-cycle wr/rd strobes, read data valid in the following cycle
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

// What this block does
// R1: temperature enable bit 12 powers the die sensor, seen on channel 4
// R2: bit 10 picks tracking or held bandgap reference for the regulator
// R3: chopper bit 9 takes two opposite-sign samples per conversion
// R4: sign bit 8 inverts input and output polarity
// R5: mute bit 7 mutes the input for a mid-scale sample
// R6: bit 6 selects differential (0) or single-ended (1) input
// R7: mask bit 5 passes or blocks the done flag toward interrupts
// R8: done flag bit 4 set on completion, read-only to software
// R9: any write to the clear register clears the done flag
// R10: bit 3 enables DMA requests for results
// R11: with continuous bit 2 clear, one result per start
// R12: result and channel selection registers are decoded
// R13: positive offset, negative offset and trim registers are decoded
// R14: continuous mode keeps converting, spaced by the gap field
// R15: start begins a conversion, cleared on completion; no rewrite while set
// R16: interrupt line high while done flag and mask are both set
// R17: reserved bit 11 and bits 15:13 of control read zero
module gca_regbank import gca_pkg::*; #(
    parameter int RES_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DW-1:0] rdata_ff,
    input wire logic sample_valid,
    input wire logic [RES_W-1:0] sample_data,
    output logic sample_req,
    output logic sample_sign,
    output gca_ana_t ana_ff,
    output gca_cfg_t cfg_ff,
    output logic done_irq_ff,
    output logic evt_irq_ff,
    output logic dma_req_ff
);

    // ****************************************
    // address decode
    // ****************************************
    function automatic gca_reg_t reg_of(input logic [AW-1:0] a);
        unique case (a)
            OFS_CTRL: reg_of = RI_CTRL;
            OFS_CTRL2: reg_of = RI_CTRL2;
            OFS_CTRL3: reg_of = RI_CTRL3;
            OFS_SEL: reg_of = RI_SEL;
            OFS_OFFP: reg_of = RI_OFFP;
            OFS_OFFN: reg_of = RI_OFFN;
            OFS_TRIM: reg_of = RI_TRIM;
            OFS_CLEAR: reg_of = RI_CLEAR;
            OFS_RESULT: reg_of = RI_RESULT;
            OFS_EVT_STAT: reg_of = RI_STAT;
            OFS_EVT_MASK: reg_of = RI_MASK;
            default: reg_of = RI_NONE;
        endcase
    endfunction

    gca_reg_t wr_reg;
    gca_reg_t rd_reg;
    logic [DW-1:0] ctrl_ff;
    logic [DW-1:0] nxt_ctrl;
    logic start_ff;
    logic flag_ff;
    logic nxt_flag;
    logic [EV_N-1:0] mask_ff;
    logic [EV_N-1:0] stat;
    logic [EV_N-1:0] ev;
    logic start_wr;
    logic go;
    logic refused;
    logic clr_wr;
    logic res_valid;
    logic fin;
    logic [RES_W-1:0] result;
    logic [DW-1:0] ctrl_view;
    logic [DW-1:0] rmux;

    assign wr_reg = wr ? reg_of(addr) : RI_NONE;
    assign rd_reg = rd ? reg_of(addr) : RI_NONE;
    assign start_wr = wr_reg == RI_CTRL && wdata[B_START];
    // a start written while one runs is refused and reported
    assign go = start_wr && !start_ff; // R15
    assign refused = start_wr && start_ff; // R15
    assign clr_wr = wr_reg == RI_CLEAR; // R9

    // ****************************************
    // main control register
    // ****************************************
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_reg == RI_CTRL) begin
            nxt_ctrl = wdata & CTRL_RW_MASK; // R17
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= RST_CTRL;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // start stays set for the whole of a continuous run
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_ff <= 1'b0;
        end else if (go) begin
            start_ff <= 1'b1; // R15
        end else if (fin) begin
            start_ff <= 1'b0; // R15
        end
    end

    // ****************************************
    // done flag and its interrupt line
    // ****************************************
    // set wins over a clear arriving in the same cycle
    assign nxt_flag = res_valid || (flag_ff && !clr_wr); // R8 R9

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_ff <= 1'b0;
            done_irq_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
            done_irq_ff <= nxt_flag && nxt_ctrl[B_MINT]; // R7 R16
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff.ctrl2 <= RST_CTRL2;
            cfg_ff.ctrl3 <= RST_CTRL3;
            cfg_ff.sel <= RST_SEL;
            cfg_ff.offp <= RST_OFFP;
            cfg_ff.offn <= RST_OFFN;
            cfg_ff.trim <= RST_TRIM;
        end else begin
            unique case (wr_reg)
                RI_CTRL2: cfg_ff.ctrl2 <= wdata;
                RI_CTRL3: cfg_ff.ctrl3 <= wdata;
                RI_SEL: cfg_ff.sel <= wdata; // R12
                RI_OFFP: cfg_ff.offp <= wdata; // R13
                RI_OFFN: cfg_ff.offn <= wdata; // R13
                RI_TRIM: cfg_ff.trim <= wdata; // R13
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= '0;
        end else if (wr_reg == RI_MASK) begin
            mask_ff <= wdata[EV_N-1:0];
        end
    end

    // ****************************************
    // analog option outputs
    // ****************************************
    // sign polarity goes out through the sequencer so chopping can flip it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ana_ff <= '0;
        end else begin
            ana_ff.temp_on_ch4 <= ctrl_ff[B_TEMP]; // R1
            ana_ff.ref_hold <= ctrl_ff[B_HOLD]; // R2
            ana_ff.mute <= ctrl_ff[B_MUTE]; // R5
            ana_ff.single_ended <= ctrl_ff[B_SE]; // R6
            ana_ff.conv_en <= ctrl_ff[B_EN];
            ana_ff.dma_en <= ctrl_ff[B_DMA]; // R10
        end
    end

    // ****************************************
    // sequencer and events
    // ****************************************
    gca_conv_seq #(
        .RES_W(RES_W),
        .GW(GAP_W)
    ) u_seq (
        .clk(clk),
        .rst_n(rst_n),
        .go(go),
        .chop(ctrl_ff[B_CHOP]),
        // a sign written together with start must already steer that first sample
        .sign(nxt_ctrl[B_SIGN]), // R4
        .cont(ctrl_ff[B_CONT]),
        .gap(cfg_ff.ctrl3[GAP_LSB +: GAP_W]),
        .sample_valid(sample_valid),
        .sample_data(sample_data),
        .sample_req_ff(sample_req),
        .sample_sign_ff(sample_sign),
        .res_valid_ff(res_valid),
        .res_ff(result),
        .fin_ff(fin)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_req_ff <= 1'b0;
        end else begin
            dma_req_ff <= res_valid && ctrl_ff[B_DMA]; // R10
        end
    end

    always_comb begin
        ev = '0;
        ev[EV_DONE] = res_valid;
        ev[EV_REFUSED] = refused;
        ev[EV_OVERRUN] = res_valid && flag_ff && !clr_wr;
    end

    gca_evt_irq #(
        .N(EV_N)
    ) u_evt (
        .clk(clk),
        .rst_n(rst_n),
        .ev(ev),
        .rd_clr(rd_reg == RI_STAT),
        .mask(mask_ff),
        .stat_ff(stat),
        .irq_ff(evt_irq_ff)
    );

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        ctrl_view = ctrl_ff & CTRL_RW_MASK; // R17
        ctrl_view[B_START] = start_ff;
        ctrl_view[B_INT] = flag_ff; // R8
        rmux = '0;
        unique case (rd_reg)
            RI_CTRL: rmux = ctrl_view;
            RI_CTRL2: rmux = cfg_ff.ctrl2;
            RI_CTRL3: rmux = cfg_ff.ctrl3;
            RI_SEL: rmux = cfg_ff.sel; // R12
            RI_OFFP: rmux = cfg_ff.offp; // R13
            RI_OFFN: rmux = cfg_ff.offn; // R13
            RI_TRIM: rmux = cfg_ff.trim; // R13
            RI_RESULT: rmux = DW'(result); // R12
            RI_STAT: rmux = DW'(stat);
            RI_MASK: rmux = DW'(mask_ff);
            default: rmux = '0;
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= rmux;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_temp_follow;
        wr_reg == RI_CTRL |-> ##2 ana_ff.temp_on_ch4 == $past(wdata[B_TEMP], 2);
    endproperty
    a_temp_follow: assert property (p_temp_follow) else $error("temp enable wrong"); // R1

    property p_se_follow;
        wr_reg == RI_CTRL |-> ##2 ana_ff.single_ended == $past(wdata[B_SE], 2);
    endproperty
    a_se_follow: assert property (p_se_follow) else $error("input mode wrong"); // R6

    property p_irq_line;
        done_irq_ff == (flag_ff && ctrl_ff[B_MINT]);
    endproperty
    a_irq_line: assert property (p_irq_line) else $error("irq line mismatch"); // R16

    property p_flag_set;
        res_valid |=> flag_ff;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("done flag not set"); // R8

    property p_flag_clear;
        clr_wr && !res_valid |=> !flag_ff;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("done flag not cleared"); // R9

    property p_start_clear;
        fin && !go |=> !start_ff;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start not cleared"); // R15

    property p_rsvd_zero;
        rd_reg == RI_CTRL |=> rdata_ff[15:13] == 3'h0 && !rdata_ff[11];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set"); // R17

    property p_dma_gate;
        dma_req_ff |-> $past(res_valid) && $past(ctrl_ff[B_DMA]);
    endproperty
    a_dma_gate: assert property (p_dma_gate) else $error("dma without enable"); // R10

    property p_manual_one;
        res_valid && !$past(ctrl_ff[B_CONT]) && !ctrl_ff[B_CONT] |-> !sample_req;
    endproperty
    a_manual_one: assert property (p_manual_one) else $error("manual kept running"); // R11

    property p_result_read;
        rd_reg == RI_RESULT |=> rdata_ff == DW'($past(result));
    endproperty
    a_result_read: assert property (p_result_read) else $error("result read wrong"); // R12

    property p_offp_read;
        rd_reg == RI_OFFP |=> rdata_ff == $past(cfg_ff.offp);
    endproperty
    a_offp_read: assert property (p_offp_read) else $error("offset read wrong"); // R13

    property p_sign_go;
        go |=> sample_req && sample_sign == $past(wdata[B_SIGN]);
    endproperty
    a_sign_go: assert property (p_sign_go) else $error("first sample polarity wrong"); // R4

    property p_hold_follow;
        wr_reg == RI_CTRL |-> ##2 ana_ff.ref_hold == $past(wdata[B_HOLD], 2);
    endproperty
    a_hold_follow: assert property (p_hold_follow) else $error("reference hold wrong"); // R2

    property p_mute_follow;
        wr_reg == RI_CTRL |-> ##2 ana_ff.mute == $past(wdata[B_MUTE], 2);
    endproperty
    a_mute_follow: assert property (p_mute_follow) else $error("mute select wrong"); // R5

    c_manual: cover property (go ##[1:200] fin);
    c_chop: cover property (go && ctrl_ff[B_CHOP] ##[1:200] res_valid);
    c_cont: cover property (res_valid ##[1:300] res_valid);
    c_refused: cover property (refused);

endmodule

// File: tb/gca_regbank_tb.sv
// self-checking bench of the converter register bank
// assumes the design's own assertions ride along; bench plays bus master and core
`timescale 1ns/1ps
module gca_regbank_tb import gca_pkg::*;;

    // ****************************************
    // signals and instance
    // ****************************************
    logic clk, rst_n, wr, rd, sample_valid, sample_req, sample_sign;
    logic done_irq_ff, evt_irq_ff, dma_req_ff;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata, rdata_ff, sample_data, d;
    gca_ana_t ana_ff;
    gca_cfg_t cfg_ff;
    int failures, checks_done, cycles, n_samp, n_dma, n0;
    int abit[6] = '{12, 10, 7, 6, 0, 3};

    gca_regbank DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata_ff(rdata_ff), .sample_valid(sample_valid),
        .sample_data(sample_data), .sample_req(sample_req), .sample_sign(sample_sign),
        .ana_ff(ana_ff), .cfg_ff(cfg_ff), .done_irq_ff(done_irq_ff),
        .evt_irq_ff(evt_irq_ff), .dma_req_ff(dma_req_ff));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // core stand-in: sample value tells the polarity used, so a chop average is 0x0200
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_valid <= 1'b0;
            sample_data <= 16'h0000;
        end else begin
            sample_valid <= sample_req && !sample_valid;
            sample_data <= sample_sign ? 16'h0300 : 16'h0100;
        end
    end

    always @(posedge clk) begin
        if (sample_valid && sample_req) n_samp++;
        if (dma_req_ff === 1'b1) n_dma++;
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("[ERR] %0t run did not finish", $time);
            print_verdict();
        end
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata_ff;
    endtask

    task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string what);
        logic [DW-1:0] v;
        rd_reg(a, v);
        chk(v, exp, what);
    endtask

    // one conversion, polled through the start bit, then the flag is cleared
    task automatic run_conv(input logic [DW-1:0] v, input logic [DW-1:0] res, input int ns);
        logic [DW-1:0] c;
        int s0, d0;
        s0 = n_samp;
        d0 = n_dma;
        c = 16'h0002;
        wr_reg(OFS_CTRL, v);
        for (int i = 0; i < 50 && c[1] !== 1'b0; i++) rd_reg(OFS_CTRL, c);
        chk(c, (v & CTRL_RW_MASK) | 16'h0010, "ctrl after done");
        rd_chk(OFS_RESULT, res, "result");
        chk(16'(n_samp - s0), 16'(ns), "sample count");
        chk({15'h0, done_irq_ff}, {15'h0, v[5]}, "done irq");
        chk(16'(n_dma - d0), {15'h0, v[3]}, "dma pulses");
        wr_reg(OFS_CLEAR, ~v);
        rd_chk(OFS_CTRL, v & CTRL_RW_MASK, "flag cleared");
        chk({15'h0, done_irq_ff}, 16'h0000, "irq after clear");
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;

        rd_chk(OFS_CTRL, 16'h0000, "ctrl reset");
        @(posedge clk);
        #1 chk(rdata_ff, 16'h0000, "rdata one cycle");
        rd_chk(OFS_CTRL2, 16'h0210, "ctrl2 reset");
        rd_chk(OFS_RESULT, 16'h0000, "result reset");
        $display("test reset done");

        for (int i = 0; i < 6; i++) wr_reg(OFS_CTRL2 + 32'(2 * i), 16'hA5C0 + 16'(i));
        for (int i = 0; i < 6; i++) rd_chk(OFS_CTRL2 + 32'(2 * i), 16'hA5C0 + 16'(i), "rw");
        chk(cfg_ff.sel, 16'hA5C2, "sel out");
        wr_reg(32'h5000_1520, 16'hFFFF);
        rd_chk(32'h5000_1520, 16'h0000, "unmapped");
        wr_reg(OFS_RESULT, 16'hFFFF);
        rd_chk(OFS_RESULT, 16'h0000, "result read-only");
        wr_reg(OFS_CTRL3, 16'h0000);
        $display("test decode done");

        wr_reg(OFS_CTRL, 16'hFFF9);
        rd_chk(OFS_CTRL, 16'h17E9, "ctrl rw bits");
        for (int k = 0; k < 6; k++) begin
            wr_reg(OFS_CTRL, 16'h0001 << abit[k]);
            rd_reg(OFS_CTRL, d);
            chk({10'h0, ana_ff}, 16'h0020 >> k, "analog select");
        end
        wr_reg(OFS_CTRL, 16'h0010);
        rd_chk(OFS_CTRL, 16'h0000, "flag not writable");
        $display("test control bits done");

        rd_reg(OFS_EVT_STAT, d);
        wr_reg(OFS_EVT_MASK, 16'h0007);
        run_conv(16'h002A, 16'h0100, 1);
        run_conv(16'h0002, 16'h0100, 1);
        run_conv(16'h0302, 16'h0200, 2);
        run_conv(16'h0102, 16'h0300, 1);
        run_conv(16'h14C2, 16'h0100, 1);
        chk({15'h0, evt_irq_ff}, 16'h0001, "event irq up");
        rd_chk(OFS_EVT_STAT, 16'h0001, "event status");
        chk({15'h0, evt_irq_ff}, 16'h0000, "event irq cleared");
        $display("test manual done");

        wr_reg(OFS_CTRL3, 16'h0300);
        n0 = n_samp;
        wr_reg(OFS_CTRL, 16'h0006);
        repeat (40) @(posedge clk);
        chk({15'h0, (n_samp - n0) >= 4}, 16'h0001, "continuous results");
        wr_reg(OFS_CTRL, 16'h0006);
        wr_reg(OFS_CTRL, 16'h0000);
        repeat (20) @(posedge clk);
        n0 = n_samp;
        repeat (20) @(posedge clk);
        chk(16'(n_samp - n0), 16'h0000, "stopped");
        rd_chk(OFS_CTRL, 16'h0010, "start cleared");
        rd_chk(OFS_EVT_STAT, 16'h0007, "refused and overrun");
        wr_reg(OFS_CLEAR, 16'h0000);
        rd_chk(OFS_CTRL, 16'h0000, "clear after run");
        $display("test continuous done");
        print_verdict();
    end

endmodule
